// ---- secure_boot_map.vh ----
// Constants for the security and boot configuration block.
// Included by the block and by its register store; holds definitions only.
`ifndef SECURE_BOOT_MAP_VH
`define SECURE_BOOT_MAP_VH

// Register offsets on the APB slave (byte addresses, one word each).
`define SB_OFF_SETTING   12'h000
`define SB_OFF_CONTROL   12'h004
`define SB_OFF_STATUS    12'h008

// Field positions inside the security setting byte.
`define SB_BIT_LOCK      0
`define SB_BIT_INHIBIT   1
`define SB_BIT_STRAP2    4
`define SB_BIT_STRAP4    5

// Field positions inside the control register.
`define SB_CTL_PROG_MODE 0
`define SB_CTL_ERASE_ALL 1

// Field positions inside the status register.
`define SB_ST_LOCKED     0
`define SB_ST_BOOT_LDR   1
`define SB_ST_PROG_MODE  2
`define SB_ST_REFUSED    3

// Erased value of the setting byte: every bit reads one.
`define SB_ERASED        8'hff
`define SB_WIDTH         8

`endif

// ---- secure_setting_store.v ----
// Non-volatile store for the security setting byte.
// Assumes the caller only asserts a program or erase strobe when allowed.
`timescale 1ns/100ps
`include "secure_boot_map.vh"

module secure_setting_store
(
   input  wire                    i_ref_clk,
   input  wire                    i_resetn,
   input  wire                    i_program,
   input  wire [`SB_WIDTH-1:0]    i_program_data,
   input  wire                    i_erase_all,
   output reg  [`SB_WIDTH-1:0]    o_setting
);

   // Reset stands in for power-up of an erased cell array.
   // Programming can only pull bits toward zero; erase restores all ones.
   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_setting <= `SB_ERASED;
      else if (i_erase_all)
         o_setting <= `SB_ERASED;
      else if (i_program)
         o_setting <= o_setting & i_program_data;
   end

endmodule // secure_setting_store

// ---- code_security_boot_config.v ----
// Security and boot configuration logic for the on-chip flash program memory.
// Assumes an APB master in programming mode and a CPU core that honours
// the boot selection and the table-read gate; pins are synchronous.
//
// Behaviour
// - A programmed lock bit refuses external reads of flash and settings.
// - With inhibit at zero, table reads from external code stay external.
// - Table reads from internal code may always reach both memories.
// - With the inhibit bit at one, table reads are not restricted.
// - Port 2 strap enabled, bits 6 and 7 low in reset: boot the loader.
// - Port 4 strap enabled, bit 3 low in reset: boot the loader bank.
// - Every setting bit reads one when erased, zero enables its feature.
// - A programmed bit returns to one only through erase-all or the i_resetn reset.
// - The setting register is reachable only in flash programming mode.
`timescale 1ns/100ps
`include "secure_boot_map.vh"

module code_security_boot_config
(
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   input  wire        i_cpu_reset,
   input  wire        i_port2_bit6_strap,
   input  wire        i_port2_bit7_strap,
   input  wire        i_port4_bit3_strap,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   input  wire        i_flash_read_req,
   input  wire [31:0] i_flash_rdata,
   input  wire        i_tr_valid,
   input  wire        i_tr_from_internal,
   input  wire        i_tr_target_internal,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr,
   output reg  [31:0] o_flash_out,
   output reg         o_flash_out_valid,
   output reg         o_tr_grant_internal,
   output reg         o_tr_redirect_external,
   output reg         o_boot_loader_bank,
   output reg         o_table_read_inhibit
);

   // One-hot phase codes of the bus slave.
   localparam ST_IDLE   = 2'b01;
   localparam ST_ACCESS = 2'b10;

   // Bus phase, mode and configuration samples.
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg         prog_mode;
   reg         refused;
   reg         lock_applied;
   reg         strap_boot;
   reg         inhibit_sampled;
   // Wires derived from the bus and the store.
   wire [7:0]  setting;
   wire        setup;
   wire        prog_stb;
   wire        erase_stb;
   wire        live_lock;
   wire        boot_now;
   wire [11:0] addr;

   // Address alias, setup-phase decode and the live lock level.
   assign addr  = i_paddr;
   assign setup = i_psel & ~i_penable;
   assign live_lock = ~setting[`SB_BIT_LOCK];

   // Program strobe is allowed only in programming mode and before locking.
   assign prog_stb  = (state == ST_ACCESS) & i_pwrite & prog_mode
                      & ~live_lock & (addr == `SB_OFF_SETTING);
   assign erase_stb = (state == ST_ACCESS) & i_pwrite
                      & (addr == `SB_OFF_CONTROL)
                      & i_pwdata[`SB_CTL_ERASE_ALL] & prog_mode;

   // The store only ever sees strobes that are already allowed.
   secure_setting_store u_store
   (
      .i_ref_clk      (i_ref_clk),
      .i_resetn       (i_resetn),
      .i_program      (prog_stb),
      .i_program_data (i_pwdata[7:0]),
      .i_erase_all    (erase_stb),
      .o_setting      (setting)
   );

   // Two-state APB slave: answers one cycle after the setup cycle.
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:   if (setup) next_state = ST_ACCESS;
         ST_ACCESS: next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   // Strap decode: either enabled strap condition selects the loader bank.
   assign boot_now =
      (~setting[`SB_BIT_STRAP2] & ~i_port2_bit6_strap
       & ~i_port2_bit7_strap)
      | (~setting[`SB_BIT_STRAP4] & ~i_port4_bit3_strap);

   // Bus, mode and sampled state. Sampling follows the CPU reset so that a
   // pin change during normal running cannot switch the boot bank.
   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state        <= ST_IDLE;
         prog_mode    <= 1'b0;
         refused      <= 1'b0;
         o_prdata     <= 32'h0000_0000;
         o_pready     <= 1'b0;
         o_pslverr    <= 1'b0;
         lock_applied <= 1'b0;
         strap_boot   <= 1'b0;
         inhibit_sampled <= 1'b0;
         o_boot_loader_bank   <= 1'b0;
         o_table_read_inhibit <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         o_pready  <= (next_state == ST_ACCESS);
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         // Sampled while the CPU is held in reset. A strap or setting change
         // at run time waits for the next reset, so the bank cannot flip.
         if (i_cpu_reset)
         begin
            lock_applied    <= live_lock;
            strap_boot      <= boot_now;
            inhibit_sampled <= ~setting[`SB_BIT_INHIBIT];
         end
         else
         begin
            o_boot_loader_bank   <= strap_boot;
            o_table_read_inhibit <= inhibit_sampled;
         end
         // A clear from software; a refusal decoded below in the same
         // cycle is assigned later and so wins.
         if (state == ST_ACCESS && i_pwrite && addr == `SB_OFF_STATUS
             && i_pwdata[`SB_ST_REFUSED])
            refused <= 1'b0;
         // Decode at setup so the answer stands in the access cycle.
         if (next_state == ST_ACCESS)
         begin
            case (addr)
               `SB_OFF_SETTING:
               begin
                  // Locked or out of mode: refuse with an error, no data.
                  if (!prog_mode || live_lock)
                  begin
                     o_pslverr <= 1'b1;
                     refused   <= 1'b1;
                  end
                  else if (!i_pwrite)
                     o_prdata <= {24'h00_0000, setting};
               end
               `SB_OFF_CONTROL:
                  if (!i_pwrite)
                     o_prdata <= {31'h0000_0000, prog_mode};
               `SB_OFF_STATUS:
                  if (!i_pwrite)
                     o_prdata <= {28'h000_0000, refused, prog_mode,
                                  strap_boot, live_lock};
               default:
                  o_pslverr <= 1'b1;
            endcase
         end
         // Programming mode follows bit 0 of every control write.
         if (state == ST_ACCESS && i_pwrite && addr == `SB_OFF_CONTROL)
            prog_mode <= i_pwdata[`SB_CTL_PROG_MODE];
      end
   end

   // Flash readback path for the programmer; closed once the lock holds.
   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_flash_out       <= 32'h0000_0000;
         o_flash_out_valid <= 1'b0;
      end
      else
      begin
         o_flash_out_valid <= i_flash_read_req & prog_mode & ~live_lock
                              & ~lock_applied;
         if (i_flash_read_req & prog_mode & ~live_lock & ~lock_applied)
            o_flash_out <= i_flash_rdata;
         else
            o_flash_out <= 32'h0000_0000;
      end
   end

   // Table-read gate: internal code always passes; external code may reach
   // internal memory only while the inhibit is clear.
   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_tr_grant_internal    <= 1'b0;
         o_tr_redirect_external <= 1'b0;
      end
      else
      begin
         o_tr_grant_internal <= i_tr_valid & i_tr_target_internal
            & (i_tr_from_internal
               | ~o_table_read_inhibit);
         o_tr_redirect_external <= i_tr_valid & i_tr_target_internal
            & ~i_tr_from_internal & o_table_read_inhibit;
      end
   end

endmodule // code_security_boot_config

// ---- csbc_props.sv ----
// Port assertions for the security and boot configuration block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module csbc_props
(
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_cpu_reset,
   input wire i_psel,
   input wire i_penable,
   input wire i_flash_read_req,
   input wire i_tr_valid,
   input wire i_tr_from_internal,
   input wire i_tr_target_internal,
   input wire o_pready,
   input wire o_pslverr,
   input wire o_flash_out_valid,
   input wire o_tr_grant_internal,
   input wire o_tr_redirect_external,
   input wire o_boot_loader_bank,
   input wire o_table_read_inhibit
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // Table read from external code aimed at internal memory, CPU running.
   wire ext_int = i_tr_valid && i_tr_target_internal && !i_tr_from_internal
                  && !i_cpu_reset;
   property p_ready; i_psel && !i_penable |=> o_pready; endproperty
   a_ready: assert property (p_ready) else $error("no pready");
   property p_ready_src; o_pready |-> i_psel && i_penable; endproperty
   a_ready_src: assert property (p_ready_src) else $error("bad pready");
   property p_err; o_pslverr |-> o_pready; endproperty
   a_err: assert property (p_err) else $error("pslverr alone");
   property p_flash; o_flash_out_valid |-> $past(i_flash_read_req); endproperty
   a_flash: assert property (p_flash) else $error("stray readback");
   property p_grant_src;
      o_tr_grant_internal |-> $past(i_tr_valid && i_tr_target_internal);
   endproperty
   a_grant_src: assert property (p_grant_src) else $error("stray grant");
   property p_inhibit;
      ext_int && o_table_read_inhibit |=>
         o_tr_redirect_external && !o_tr_grant_internal;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit leak");
   property p_internal;
      i_tr_valid && i_tr_from_internal && i_tr_target_internal
         && !i_cpu_reset |=> o_tr_grant_internal;
   endproperty
   a_internal: assert property (p_internal) else $error("int denied");
   property p_open; ext_int && !o_table_read_inhibit |=> o_tr_grant_internal;
   endproperty
   a_open: assert property (p_open) else $error("open denied");
   property p_boot_hold; i_cpu_reset |=> $stable(o_boot_loader_bank);
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("boot moved");
   c_err: cover property (o_pslverr);
   c_boot: cover property (o_boot_loader_bank && !i_cpu_reset);
   c_redir: cover property (o_tr_redirect_external);
endmodule // csbc_props

bind code_security_boot_config csbc_props csbc_props_inst (.i_ref_clk,
   .i_resetn, .i_cpu_reset, .i_psel, .i_penable, .i_flash_read_req,
   .i_tr_valid, .i_tr_from_internal, .i_tr_target_internal, .o_pready,
   .o_pslverr, .o_flash_out_valid, .o_tr_grant_internal,
   .o_tr_redirect_external, .o_boot_loader_bank, .o_table_read_inhibit);

// ---- flash_programmer.sv ----
// Device programmer model: an APB master for the setting registers.
// Assumes it is called only after reset has been released.
`timescale 1ns/100ps
module flash_programmer
(
   input  wire         i_ref_clk,
   input  wire         i_pready,
   input  wire         i_pslverr,
   input  wire  [31:0] i_prdata,
   output logic        o_psel = 1'b0,
   output logic        o_penable = 1'b0,
   output logic        o_pwrite = 1'b0,
   output logic [11:0] o_paddr = 12'h000,
   output logic [31:0] o_pwdata = 32'h0
);
   // Request held until pready is seen high, then released.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge i_ref_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_ref_clk);
      o_penable <= 1'b1;
      @(posedge i_ref_clk);
      while (!i_pready) @(posedge i_ref_clk);
      r = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule // flash_programmer

// ---- code_security_boot_config_tb_top.sv ----
// Testbench for the security and boot configuration block.
// Assumes the programmer model is the only APB master.
`timescale 1ns/100ps
module code_security_boot_config_tb_top;
   logic i_ref_clk = 0, i_resetn = 0, i_cpu_reset = 0, i_flash_read_req = 0;
   logic i_port2_bit6_strap = 1, i_port2_bit7_strap = 1;
   logic i_port4_bit3_strap = 1, i_tr_valid = 0, i_tr_from_internal = 0;
   logic i_tr_target_internal = 0, err;
   logic [31:0] i_flash_rdata = 32'h5a5a_a5a5, rd;
   wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_flash_out_valid;
   wire o_tr_grant_internal, o_tr_redirect_external, o_boot_loader_bank;
   wire o_table_read_inhibit;
   wire [11:0] i_paddr;
   wire [31:0] i_pwdata, o_prdata, o_flash_out;
   int n_errors = 0, n_compared = 0, cyc = 0;
   code_security_boot_config code_security_boot_config_inst (.i_ref_clk,
      .i_resetn, .i_cpu_reset, .i_port2_bit6_strap, .i_port2_bit7_strap,
      .i_port4_bit3_strap, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .i_flash_read_req, .i_flash_rdata, .i_tr_valid,
      .i_tr_from_internal, .i_tr_target_internal, .o_prdata, .o_pready,
      .o_pslverr, .o_flash_out, .o_flash_out_valid, .o_tr_grant_internal,
      .o_tr_redirect_external, .o_boot_loader_bank, .o_table_read_inhibit);
   flash_programmer flash_programmer_inst (.i_ref_clk, .i_pready(o_pready),
      .i_pslverr(o_pslverr), .i_prdata(o_prdata), .o_psel(i_psel),
      .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
      .o_pwdata(i_pwdata));
   always #4 i_ref_clk = ~i_ref_clk;
   task automatic print_verdict;
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   // A read expects d back; a refused read expects zero data.
   task automatic ap(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic e);
      flash_programmer_inst.xfer(w, a, d, rd, err);
      chk("pslverr", {31'h0, err}, {31'h0, e});
      if (!w) chk("prdata", rd, d);
   endtask
   // Straps are only looked at while the CPU reset pin is high.
   task automatic boot(input logic [2:0] s, input logic exp);
      @(posedge i_ref_clk);
      i_cpu_reset <= 1;
      {i_port4_bit3_strap, i_port2_bit7_strap, i_port2_bit6_strap} <= s;
      repeat (3) @(posedge i_ref_clk);
      i_cpu_reset <= 0;
      repeat (2) @(posedge i_ref_clk);
      @(negedge i_ref_clk) chk("boot", {31'h0, o_boot_loader_bank}, exp);
   endtask
   task automatic tread(input logic [2:0] t, input logic g);
      @(posedge i_ref_clk);
      {i_tr_valid, i_tr_from_internal, i_tr_target_internal} <= t;
      @(posedge i_ref_clk);
      i_tr_valid <= 0;
      @(negedge i_ref_clk) chk("grant", {31'h0, o_tr_grant_internal}, g);
      chk("redirect", {31'h0, o_tr_redirect_external}, !g);
   endtask
   // A refused readback shows zero data and no valid strobe.
   task automatic flash(input logic [31:0] exp, input logic v);
      @(posedge i_ref_clk);
      i_flash_read_req <= 1;
      @(posedge i_ref_clk);
      i_flash_read_req <= 0;
      @(negedge i_ref_clk) chk("flash", o_flash_out, exp);
      chk("flash valid", {31'h0, o_flash_out_valid}, {31'h0, v});
   endtask
   // A hang ends the run as a failure.
   always @(posedge i_ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         print_verdict;
      end
   end
   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      i_resetn <= 1;
      ap(1, 12'h000, 32'hfe, 1);
      ap(0, 12'h000, 32'h0, 1);
      ap(0, 12'h008, 32'h8, 0);
      ap(1, 12'h008, 32'h8, 0);
      ap(0, 12'h008, 32'h0, 0);
      ap(0, 12'h00c, 32'h0, 1);
      ap(1, 12'h004, 32'h1, 0);
      ap(0, 12'h004, 32'h1, 0);
      ap(0, 12'h000, 32'hff, 0);
      ap(1, 12'h000, 32'hcd, 0);
      ap(1, 12'h000, 32'hff, 0);
      ap(0, 12'h000, 32'hcd, 0);
      boot(3'h4, 1);
      chk("inhibit", {31'h0, o_table_read_inhibit}, 1);
      tread(3'h5, 0);
      tread(3'h7, 1);
      flash(32'h5a5a_a5a5, 1);
      ap(1, 12'h004, 32'h3, 0);
      ap(0, 12'h000, 32'hff, 0);
      ap(1, 12'h000, 32'hdf, 0);
      boot(3'h3, 1);
      boot(3'h4, 0);
      tread(3'h5, 1);
      ap(1, 12'h000, 32'hde, 0);
      ap(0, 12'h000, 32'h0, 1);
      flash(32'h0, 0);
      boot(3'h4, 0);
      ap(1, 12'h004, 32'h3, 0);
      ap(0, 12'h000, 32'hff, 0);
      flash(32'h0, 0);
      print_verdict;
   end
endmodule // code_security_boot_config_tb_top
